// [include/mic_params.svh]
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH
// register byte addresses
`define MIC_ADR_CTRL 7'h0B
`define MIC_ADR_REQ0 13'h070C
`define MIC_ADR_PEN0 13'h0716
`define MIC_ADR_PEN1 13'h0717
// shadow copies in bank 63
`define MIC_ADR_SH_STAT 13'h1FE4
`define MIC_ADR_SH_WORKING_REGISTER 13'h1FE5
`define MIC_ADR_SH_BSR 13'h1FE6
`define MIC_ADR_SH_PCH 13'h1FE7
`define MIC_ADR_SH_F0L 13'h1FE8
`define MIC_ADR_SH_F0H 13'h1FE9
`define MIC_ADR_SH_F1L 13'h1FEA
`define MIC_ADR_SH_F1H 13'h1FEB
// control register fields
`define MIC_B_GIE 7
`define MIC_B_PERIPH_IRQ_GATE 6
`define MIC_B_EDGE 0
// enable register 0 fields
`define MIC_B_TMR0 5
`define MIC_B_IOC 4
`define MIC_B_EXT 0
// status bits that are shadowed
`define MIC_STAT_KEEP 8'hE7
// reset values
`define MIC_RST_CTRL 8'h01
`define MIC_RST_PEN 8'h00
// vector and stack
`define MIC_VECTOR 15'h0004
`define MIC_STK_DEPTH 16
`endif

// [include/mic_pkg.sv]
package mic_pkg;
	// sequencer states
	typedef enum logic [1:0] {
		MIC_RUN = 2'b00,
		MIC_POST = 2'b01
	} mic_state_t;
endpackage : mic_pkg

// [verilog/mic_irq_ctrl.sv]
`include "mic_params.svh"
// Function
// R1: wake request reaches core without clock
// R2: software enables wake sources before sleeping
// R3: wake vectors if global enabled, else resumes
// R4: one instruction after sleep runs first
// R5: external pin gives edge triggered request
// R6: edge select bit zero, reset one
// R7: selected edge sets flag, vectors if enabled
// R8: entry pushes return address on stack
// R9: entry copies core registers into shadows
// R10: return reloads registers from shadow copies
// R11: shadows readable and writable in bank 63
// R12: global enable bit seven gates vectoring, not wake
// R13: peripheral gate bit six gates peripherals
// R14: flags set regardless of any enable
// R15: software clears flag before enabling it
// R16: register 0 sources ignore peripheral gate
// R17: register 1 sources need peripheral gate
// R18: register 0 holds timer0, change, pin
// R19: register 1 holds eight peripheral enables
// R20: entry clears global enable, loads vector
// R21: return pops, restores, sets global enable
// R22: pin flag at request register 0 bit 0
// R23: pin request synchronised before vectoring
module mic_irq_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register port
	input wire logic [12:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// flag sources
	input wire logic ext_pin,
	input wire logic timer0_flag,
	input wire logic pin_change_flag,
	input wire logic [7:0] periph1_flags,
	input wire logic periph2_req,
	// core sequencer
	input wire logic sleep_active,
	input wire logic instr_done,
	input wire logic irq_ack,
	input wire logic return_from_irq_instr_exec,
	input wire logic [14:0] core_pc,
	output logic irq_req,
	output logic wake_req,
	output logic pc_load,
	output logic [14:0] pc_value,
	// live core registers
	input wire logic [7:0] working_register,
	input wire logic [7:0] status_reg,
	input wire logic [7:0] bank_select_register,
	input wire logic [7:0] pc_high_latch,
	input wire logic [31:0] indirect_pointer_register,
	// restore path
	output logic restore,
	output logic [7:0] rst_working,
	output logic [7:0] rst_status,
	output logic [7:0] rst_bank,
	output logic [7:0] rst_pch,
	output logic [31:0] rst_pointer
);

////////////////////////////////////////////////////////////////////////////////
// declarations

logic global_irq_enable_ff; // master gate
logic periph_irq_gate_ff; // peripheral gate
logic ext_edge_select_ff; // 1 rising, 0 falling
logic [7:0] pen0_ff; // enable register 0
logic [7:0] pen1_ff; // enable register 1
logic ext_pin_irq_flag_ff; // sticky pin flag
logic [2:0] pin_sync_ff; // synchroniser plus history
logic [7:0] sh_stat_ff;
logic [7:0] sh_working_register_ff;
logic [7:0] sh_bsr_ff;
logic [7:0] sh_pch_ff;
logic [31:0] sh_ptr_ff;
logic [14:0] stack_ff [`MIC_STK_DEPTH];
logic [3:0] sp_ff; // next free slot
logic [7:0] rdata_ff;
mic_pkg::mic_state_t state_ff;
mic_pkg::mic_state_t nxt_state;
logic entry; // interrupt being taken
logic ext_edge; // selected pin edge
logic pend0; // register 0 sources pending
logic pend1; // gated sources pending
logic pending;
logic wr_ctrl;
logic wr_req0;

////////////////////////////////////////////////////////////////////////////////
// request gating

assign wr_ctrl = reg_wr && (reg_addr[6:0] == `MIC_ADR_CTRL);
assign wr_req0 = reg_wr && (reg_addr == `MIC_ADR_REQ0);

// register 0 sources skip the peripheral gate
always_comb begin
	pend0 = (pen0_ff[`MIC_B_TMR0] && timer0_flag) // R16 R18
		|| (pen0_ff[`MIC_B_IOC] && pin_change_flag)
		|| (pen0_ff[`MIC_B_EXT] && ext_pin_irq_flag_ff);
	pend1 = periph_irq_gate_ff && ((|(pen1_ff & periph1_flags)) || periph2_req); // R13 R17
	pending = pend0 || pend1;
end

// no vector while asleep or while the post-wake instruction runs
assign irq_req = global_irq_enable_ff && pending && !sleep_active
	&& (state_ff == mic_pkg::MIC_RUN); // R12 R7 R4
assign entry = irq_ack && irq_req;

// pure gates only, so a stopped clock still wakes the core
assign wake_req = sleep_active && pending; // R1

////////////////////////////////////////////////////////////////////////////////
// external pin edge detect

// first stage feeds only the second
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		pin_sync_ff <= 3'h0;
	end else begin
		pin_sync_ff <= {pin_sync_ff[1:0], ext_pin}; // R23
	end
end

// compare stages two and three against the chosen polarity
assign ext_edge = ext_edge_select_ff ?
	(pin_sync_ff[1] && !pin_sync_ff[2]) : // R6
	(!pin_sync_ff[1] && pin_sync_ff[2]); // R5

// set wins over a software clear in the same cycle
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		ext_pin_irq_flag_ff <= 1'b0;
	end else if (ext_edge) begin
		ext_pin_irq_flag_ff <= 1'b1; // R7 R14
	end else if (wr_req0) begin
		ext_pin_irq_flag_ff <= reg_wdata[0]; // R22
	end
end

////////////////////////////////////////////////////////////////////////////////
// control and enable registers

// hardware entry and return override a software write
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		global_irq_enable_ff <= 1'b0;
	end else if (entry) begin
		global_irq_enable_ff <= 1'b0; // R20
	end else if (return_from_irq_instr_exec) begin
		global_irq_enable_ff <= 1'b1; // R21
	end else if (wr_ctrl) begin
		global_irq_enable_ff <= reg_wdata[`MIC_B_GIE]; // R12
	end
end

// remaining control bits
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		periph_irq_gate_ff <= 1'(`MIC_RST_CTRL >> `MIC_B_PERIPH_IRQ_GATE);
		ext_edge_select_ff <= 1'b1; // R6
	end else if (wr_ctrl) begin
		periph_irq_gate_ff <= reg_wdata[`MIC_B_PERIPH_IRQ_GATE]; // R13
		ext_edge_select_ff <= reg_wdata[`MIC_B_EDGE]; // R6
	end
end

// enable registers; unused bits of register 0 stay zero
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		pen0_ff <= `MIC_RST_PEN;
		pen1_ff <= `MIC_RST_PEN;
	end else if (reg_wr) begin
		if (reg_addr == `MIC_ADR_PEN0) begin
			pen0_ff <= reg_wdata & 8'h31; // R18
		end else if (reg_addr == `MIC_ADR_PEN1) begin
			pen1_ff <= reg_wdata; // R19
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// shadow registers

// entry snapshot beats a software write
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		sh_stat_ff <= 8'h00;
		sh_working_register_ff <= 8'h00;
		sh_bsr_ff <= 8'h00;
		sh_pch_ff <= 8'h00;
		sh_ptr_ff <= 32'h0;
	end else if (entry) begin
		sh_stat_ff <= status_reg & `MIC_STAT_KEEP; // R9
		sh_working_register_ff <= working_register;
		sh_bsr_ff <= bank_select_register;
		sh_pch_ff <= pc_high_latch;
		sh_ptr_ff <= indirect_pointer_register;
	end else if (reg_wr) begin
		if (reg_addr == `MIC_ADR_SH_STAT) begin
			sh_stat_ff <= reg_wdata & `MIC_STAT_KEEP; // R11
		end else if (reg_addr == `MIC_ADR_SH_WORKING_REGISTER) begin
			sh_working_register_ff <= reg_wdata;
		end else if (reg_addr == `MIC_ADR_SH_BSR) begin
			sh_bsr_ff <= reg_wdata;
		end else if (reg_addr == `MIC_ADR_SH_PCH) begin
			sh_pch_ff <= reg_wdata;
		end else if (reg_addr == `MIC_ADR_SH_F0L) begin
			sh_ptr_ff[7:0] <= reg_wdata;
		end else if (reg_addr == `MIC_ADR_SH_F0H) begin
			sh_ptr_ff[15:8] <= reg_wdata;
		end else if (reg_addr == `MIC_ADR_SH_F1L) begin
			sh_ptr_ff[23:16] <= reg_wdata;
		end else if (reg_addr == `MIC_ADR_SH_F1H) begin
			sh_ptr_ff[31:24] <= reg_wdata;
		end
	end
end

// restore strobe; core overwrites its live copies with these
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		restore <= 1'b0;
	end else begin
		restore <= return_from_irq_instr_exec; // R10
	end
end
assign rst_working = sh_working_register_ff;
assign rst_status = sh_stat_ff;
assign rst_bank = sh_bsr_ff;
assign rst_pch = sh_pch_ff;
assign rst_pointer = sh_ptr_ff;

////////////////////////////////////////////////////////////////////////////////
// return stack and program counter load

// overflow wraps silently, as small cores do
always_ff @(posedge clk) begin
	if (entry) begin
		stack_ff[sp_ff] <= core_pc; // R8
	end
end

// pointer moves on entry and return
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		sp_ff <= 4'h0;
	end else if (entry) begin
		sp_ff <= sp_ff + 4'h1; // R8
	end else if (return_from_irq_instr_exec) begin
		sp_ff <= sp_ff - 4'h1; // R21
	end
end

// vector on entry, popped address on return
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		pc_load <= 1'b0;
		pc_value <= 15'h0000;
	end else begin
		pc_load <= entry || return_from_irq_instr_exec;
		if (entry) begin
			pc_value <= `MIC_VECTOR; // R20
		end else if (return_from_irq_instr_exec) begin
			pc_value <= stack_ff[sp_ff - 4'h1]; // R21
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// wake sequencer

// a wake with vectoring enabled first lets one instruction run
always_comb begin
	nxt_state = state_ff;
	case (state_ff)
		mic_pkg::MIC_RUN: begin
			if (wake_req && global_irq_enable_ff) begin
				nxt_state = mic_pkg::MIC_POST; // R3 R4
			end
		end
		mic_pkg::MIC_POST: begin
			if (instr_done && !sleep_active) begin
				nxt_state = mic_pkg::MIC_RUN; // R4
			end
		end
		default: begin
			nxt_state = mic_pkg::MIC_RUN;
		end
	endcase
end

// state register
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		state_ff <= mic_pkg::MIC_RUN;
	end else begin
		state_ff <= nxt_state;
	end
end

////////////////////////////////////////////////////////////////////////////////
// read path

// data stands in the cycle after the strobe only
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		rdata_ff <= 8'h00;
	end else if (!reg_rd) begin
		rdata_ff <= 8'h00;
	end else if (reg_addr[6:0] == `MIC_ADR_CTRL) begin
		rdata_ff <= {global_irq_enable_ff, periph_irq_gate_ff, 5'h00, ext_edge_select_ff};
	end else if (reg_addr == `MIC_ADR_REQ0) begin
		rdata_ff <= {2'h0, timer0_flag, pin_change_flag, 3'h0, ext_pin_irq_flag_ff}; // R22
	end else if (reg_addr == `MIC_ADR_PEN0) begin
		rdata_ff <= pen0_ff;
	end else if (reg_addr == `MIC_ADR_PEN1) begin
		rdata_ff <= pen1_ff;
	end else if (reg_addr == `MIC_ADR_SH_STAT) begin
		rdata_ff <= sh_stat_ff; // R11
	end else if (reg_addr == `MIC_ADR_SH_WORKING_REGISTER) begin
		rdata_ff <= sh_working_register_ff;
	end else if (reg_addr == `MIC_ADR_SH_BSR) begin
		rdata_ff <= sh_bsr_ff;
	end else if (reg_addr == `MIC_ADR_SH_PCH) begin
		rdata_ff <= sh_pch_ff;
	end else if (reg_addr == `MIC_ADR_SH_F0L) begin
		rdata_ff <= sh_ptr_ff[7:0];
	end else if (reg_addr == `MIC_ADR_SH_F0H) begin
		rdata_ff <= sh_ptr_ff[15:8];
	end else if (reg_addr == `MIC_ADR_SH_F1L) begin
		rdata_ff <= sh_ptr_ff[23:16];
	end else if (reg_addr == `MIC_ADR_SH_F1H) begin
		rdata_ff <= sh_ptr_ff[31:24];
	end else begin
		rdata_ff <= 8'h00;
	end
end
assign reg_rdata = rdata_ff;

////////////////////////////////////////////////////////////////////////////////
// assertions

// entry steps
sequence entry_s;
	irq_ack && irq_req;
endsequence

sequence vector_s;
	pc_load && (pc_value == 15'h0004) && !global_irq_enable_ff;
endsequence

entry_vector_a: assert property (@(posedge clk) disable iff (!reset_n) // R20
	entry_s |=> vector_s) else $error("entry did not load vector");

entry_push_a: assert property (@(posedge clk) disable iff (!reset_n) // R8
	entry_s |=> (sp_ff == $past(sp_ff) + 4'h1))
	else $error("entry did not push");

entry_save_a: assert property (@(posedge clk) disable iff (!reset_n) // R9
	entry_s |=> (sh_working_register_ff == $past(working_register))
	&& (sh_stat_ff == ($past(status_reg) & 8'hE7))) else $error("context not saved");

ret_restore_a: assert property (@(posedge clk) disable iff (!reset_n) // R10
	return_from_irq_instr_exec && !irq_ack |=> restore && global_irq_enable_ff
	&& (rst_working == $past(sh_working_register_ff))) else $error("return did not restore");

ret_pop_a: assert property (@(posedge clk) disable iff (!reset_n) // R21
	entry_s ##1 (!return_from_irq_instr_exec && !irq_ack)[*2] ##1 return_from_irq_instr_exec && !irq_ack
	|=> pc_load && (pc_value == $past(core_pc, 4)))
	else $error("return address wrong");

edge_rise_a: assert property (@(posedge clk) disable iff (!reset_n) // R6
	ext_edge_select_ff && $rose(pin_sync_ff[1]) |=> ext_pin_irq_flag_ff)
	else $error("rising edge missed");

edge_fall_a: assert property (@(posedge clk) disable iff (!reset_n) // R14
	!ext_edge_select_ff && $fell(pin_sync_ff[1]) |=> ext_pin_irq_flag_ff)
	else $error("falling edge missed");

gate_block_a: assert property (@(posedge clk) disable iff (!reset_n) // R17
	!pend0 && !periph_irq_gate_ff |-> !irq_req) else $error("gated source vectored");

gate_pass_a: assert property (@(posedge clk) disable iff (!reset_n) // R16
	global_irq_enable_ff && pend0 && !sleep_active && state_ff == mic_pkg::MIC_RUN
	|-> irq_req) else $error("register 0 source blocked");

wake_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // R4
	wake_req && global_irq_enable_ff && state_ff == mic_pkg::MIC_RUN
	|=> !irq_req && (state_ff == mic_pkg::MIC_POST)) else $error("vectored before instruction");

wake_comb_a: assert property (@(posedge clk) disable iff (!reset_n) // R1
	sleep_active && pending |-> wake_req) else $error("wake not raised");

endmodule : mic_irq_ctrl

// [bench/mic_core_model.sv]
// core sequencer stand-in: takes vectors, runs the return, paces instructions
module mic_core_model (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// bench controls
	input wire logic hold_off,
	input wire logic [3:0] ack_delay,
	input wire logic do_ret,
	// from the block
	input wire logic irq_req,
	input wire logic pc_load,
	input wire logic [14:0] pc_value,
	// to the block
	output logic irq_ack,
	output logic return_from_irq_instr_exec,
	output logic instr_done,
	output logic [14:0] core_pc
);
	logic [3:0] wait_ff; // cycles the request has stood
	logic [1:0] pace_ff; // instruction pacing
	////////////////////////////////////////////////////////////////
	// vector take, stalled by ack_delay so slow cores are exercised
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wait_ff <= 4'h0;
			irq_ack <= 1'b0;
			return_from_irq_instr_exec <= 1'b0;
		end else begin
			irq_ack <= 1'b0;
			return_from_irq_instr_exec <= do_ret;
			if (irq_req && !irq_ack && !hold_off) begin
				wait_ff <= wait_ff + 4'h1;
				// ack only while the request stands
				irq_ack <= (wait_ff >= ack_delay);
			end else begin
				wait_ff <= 4'h0;
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// program counter walk, reloaded on every load pulse
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			core_pc <= 15'h0100;
			pace_ff <= 2'h0;
		end else begin
			pace_ff <= pace_ff + 2'h1;
			core_pc <= pc_load ? pc_value : core_pc + 15'h0001;
		end
	end
	assign instr_done = (pace_ff == 2'h3); // one instruction per four cycles
endmodule : mic_core_model

// [bench/test_mcu_interrupt_controller.sv]
`include "mic_params.svh"
module test_mcu_interrupt_controller;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [12:0] reg_addr = 13'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ext_pin = 1'b0;
	logic timer0_flag = 1'b0;
	logic p2_req = 1'b0;
	logic chg_flag = 1'b0; // pin-change flag level
	logic sleep_active = 1'b0;
	logic [7:0] periph1_flags = 8'h00;
	logic [7:0] working = 8'h5A; // live working register
	logic hold_off = 1'b1; // core refuses vectors
	logic do_ret = 1'b0;
	logic instr_done, irq_ack, return_from_irq_instr_exec, irq_req, wake_req, pc_load, restore;
	logic [7:0] reg_rdata, rd_val, rst_working, rst_status, rst_bank, rst_pch;
	logic [31:0] rst_pointer;
	logic [14:0] core_pc, pc_value, ret_pc;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	mic_irq_ctrl mic_irq_ctrl_inst (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_pin(ext_pin), .timer0_flag(timer0_flag), .pin_change_flag(chg_flag),
		.periph1_flags(periph1_flags), .periph2_req(p2_req), .sleep_active(sleep_active),
		.instr_done(instr_done), .irq_ack(irq_ack), .return_from_irq_instr_exec(return_from_irq_instr_exec),
		.core_pc(core_pc), .irq_req(irq_req), .wake_req(wake_req), .pc_load(pc_load),
		.pc_value(pc_value), .working_register(working), .status_reg(8'hFF),
		.bank_select_register(8'h3C), .pc_high_latch(8'h12),
		.indirect_pointer_register(32'h11223344), .restore(restore),
		.rst_working(rst_working), .rst_status(rst_status), .rst_bank(rst_bank),
		.rst_pch(rst_pch), .rst_pointer(rst_pointer));
	mic_core_model mic_core_model_inst (.clk(clk), .reset_n(reset_n), .hold_off(hold_off),
		.ack_delay(4'h2), .do_ret(do_ret), .irq_req(irq_req), .pc_load(pc_load),
		.pc_value(pc_value), .irq_ack(irq_ack), .return_from_irq_instr_exec(return_from_irq_instr_exec),
		.instr_done(instr_done), .core_pc(core_pc));
	////////////////////////////////////////////////////////////////
	// shared bus and compare helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [12:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask : rd
	task automatic pin(input logic v);
		@(posedge clk);
		ext_pin <= v;
		repeat (4) @(posedge clk);
	endtask : pin
	////////////////////////////////////////////////////////////////
	// reset values, access kinds, unmapped place
	task automatic t_regs;
		rd(13'h000B); chk(rd_val, 8'h01);
		rd(`MIC_ADR_PEN0); chk(rd_val, 8'h00);
		rd(`MIC_ADR_PEN1); chk(rd_val, 8'h00);
		wr(`MIC_ADR_PEN0, 8'hFF); rd(`MIC_ADR_PEN0); chk(rd_val, 8'h31);
		wr(`MIC_ADR_PEN1, 8'hA5); rd(`MIC_ADR_PEN1); chk(rd_val, 8'hA5);
		wr(13'h0500, 8'hFF); rd(13'h0500); chk(rd_val, 8'h00);
		wr(`MIC_ADR_PEN0, 8'h00);
		wr(`MIC_ADR_PEN1, 8'h00);
		$display("test regs done");
	endtask : t_regs
	// both edge selections, selected edge sets flag, other edge does not
	task automatic t_pin;
		for (int e = 1; e >= 0; e--) begin
			wr(13'h000B, {7'h00, e[0]});
			pin(~e[0]);
			wr(`MIC_ADR_REQ0, 8'h00);
			pin(e[0]);
			rd(`MIC_ADR_REQ0); chk(rd_val[0], 1'b1);
			wr(`MIC_ADR_REQ0, 8'h00);
			pin(~e[0]);
			rd(`MIC_ADR_REQ0); chk(rd_val[0], 1'b0);
		end
		$display("test pin done");
	endtask : t_pin
	// entry, shadow capture and edit, return
	task automatic t_vector;
		logic [12:0] sa [6];
		logic [7:0] sv [6];
		sa = '{`MIC_ADR_SH_WORKING_REGISTER, `MIC_ADR_SH_STAT, `MIC_ADR_SH_BSR, `MIC_ADR_SH_PCH,
			`MIC_ADR_SH_F0L, `MIC_ADR_SH_F1H};
		sv = '{8'h5A, 8'hE7, 8'h3C, 8'h12, 8'h44, 8'h11};
		wr(13'h000B, 8'h01);
		pin(1'b0);
		wr(`MIC_ADR_REQ0, 8'h00);
		wr(`MIC_ADR_PEN0, 8'h01);
		wr(13'h000B, 8'h81);
		hold_off <= 1'b0;
		ext_pin <= 1'b1;
		for (int i = 0; i < 20 && pc_load !== 1'b1; i++) begin
			@(posedge clk);
			#1 if (irq_ack === 1'b1) ret_pc = core_pc;
		end
		chk(pc_load, 1'b1);
		chk(pc_value, 15'h0004);
		rd(13'h000B); chk(rd_val, 8'h01);
		foreach (sa[i]) begin
			rd(sa[i]); chk(rd_val, sv[i]);
		end
		wr(`MIC_ADR_REQ0, 8'h00);
		wr(`MIC_ADR_SH_WORKING_REGISTER, 8'h77);
		rd(`MIC_ADR_SH_WORKING_REGISTER); chk(rd_val, 8'h77);
		@(posedge clk);
		working <= 8'h00;
		do_ret <= 1'b1;
		@(posedge clk);
		do_ret <= 1'b0;
		hold_off <= 1'b1;
		for (int i = 0; i < 10 && restore !== 1'b1; i++) @(posedge clk) #1;
		chk(restore, 1'b1);
		chk(rst_working, 8'h77);
		chk(rst_status, 8'hE7);
		chk(rst_bank, 8'h3C);
		chk(rst_pch, 8'h12);
		chk(rst_pointer, 32'h11223344);
		chk(pc_value, ret_pc);
		rd(13'h000B); chk(rd_val, 8'h81);
		wr(13'h000B, 8'h01);
		wr(`MIC_ADR_PEN0, 8'h00);
		$display("test vector done");
	endtask : t_vector
	// pin-change source vectors without the gate; return three cycles after entry
	task automatic t_quick;
		wr(`MIC_ADR_PEN0, 8'h10);
		wr(13'h000B, 8'h81);
		hold_off <= 1'b0;
		chg_flag <= 1'b1;
		for (int i = 0; i < 20 && pc_load !== 1'b1; i++) begin
			@(posedge clk);
			#1 if (irq_ack === 1'b1) ret_pc = core_pc;
		end
		chk(pc_load, 1'b1);
		chk(pc_value, 15'h0004);
		@(posedge clk);
		hold_off <= 1'b1;
		chg_flag <= 1'b0;
		do_ret <= 1'b1;
		@(posedge clk);
		do_ret <= 1'b0;
		for (int i = 0; i < 10 && restore !== 1'b1; i++) @(posedge clk) #1;
		chk(restore, 1'b1);
		chk(pc_value, ret_pc);
		wr(`MIC_ADR_PEN0, 8'h00);
		wr(13'h000B, 8'h01);
		$display("test quick done");
	endtask : t_quick
	// global and peripheral gating, then wake while asleep
	task automatic t_gate;
		wr(`MIC_ADR_PEN1, 8'h80);
		periph1_flags <= 8'h80;
		wr(13'h000B, 8'h81); #1 chk(irq_req, 1'b0);
		wr(13'h000B, 8'hC1); #1 chk(irq_req, 1'b1);
		wr(13'h000B, 8'h41);
		periph1_flags <= 8'h00;
		p2_req <= 1'b1;
		#1 chk(irq_req, 1'b0);
		wr(13'h000B, 8'h81); #1 chk(irq_req, 1'b0);
		wr(13'h000B, 8'hC1); #1 chk(irq_req, 1'b1);
		wr(`MIC_ADR_PEN1, 8'h00);
		p2_req <= 1'b0;
		wr(`MIC_ADR_PEN0, 8'h20);
		timer0_flag <= 1'b1;
		wr(13'h000B, 8'h81); #1 chk(irq_req, 1'b1);
		// asleep with vectoring off: wakes, then resumes with no vector
		wr(13'h000B, 8'h01);
		sleep_active <= 1'b1;
		@(posedge clk) #1 chk(wake_req, 1'b1);
		chk(irq_req, 1'b0);
		@(posedge clk);
		sleep_active <= 1'b0;
		#1 chk(irq_req, 1'b0);
		// asleep with vectoring on: one instruction runs before the vector
		wr(13'h000B, 8'h81);
		sleep_active <= 1'b1;
		timer0_flag <= 1'b0;
		@(posedge clk) timer0_flag <= 1'b1;
		@(posedge clk) #1 chk(wake_req, 1'b1);
		chk(irq_req, 1'b0);
		@(posedge clk) sleep_active <= 1'b0;
		#1 chk(irq_req, 1'b0);
		for (int i = 0; i < 8 && instr_done !== 1'b1; i++) @(posedge clk) #1;
		chk(irq_req, 1'b0);
		@(posedge clk) #1 chk(irq_req, 1'b1);
		// source enable off: flag up but no wake
		wr(13'h000B, 8'h01);
		sleep_active <= 1'b1;
		wr(`MIC_ADR_PEN0, 8'h00); #1 chk(wake_req, 1'b0);
		@(posedge clk);
		sleep_active <= 1'b0;
		timer0_flag <= 1'b0;
		$display("test gate done");
	endtask : t_gate
	////////////////////////////////////////////////////////////////
	// closing report, reached from the main sequence or the watchdog
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	// watchdog: the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_pin();
		t_vector();
		t_quick();
		t_gate();
		report_and_stop();
	end
endmodule : test_mcu_interrupt_controller
